// File: bench/adcsq_comp_model.sv
/*
  Behavioural model of the computation unit and trigger counter beyond the sequencer.
  Assumes the sequencer pulses conv_done for one cycle at the end of each conversion.
*/
`timescale 1ns/10ps
`default_nettype none
module adcsq_comp_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        conv_done,
  input  wire logic        ovf_in,
  input  wire logic [15:0] err_in,
  output var  logic        comp_done,
  output var  logic        comp_overflow,
  output var  logic [15:0] error_value,
  output var  logic [7:0]  trigger_counter
);
  logic [2:0] delay_reg;

  // Results are valid only with the done pulse; otherwise the lines keep toggling.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      delay_reg <= 3'h0;
      comp_done <= 1'b0;
      comp_overflow <= 1'b0;
      error_value <= 16'h0000;
      trigger_counter <= 8'h00;
    end else begin
      delay_reg <= {delay_reg[1:0], conv_done};
      comp_done <= delay_reg[2];
      if (conv_done && trigger_counter != 8'hff) begin
        trigger_counter <= trigger_counter + 8'h01;
      end
      if (delay_reg[2]) begin
        error_value <= err_in;
        comp_overflow <= ovf_in;
      end else begin
        error_value <= ~error_value;
        comp_overflow <= ~comp_overflow;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/adcsq_config_status_tb.sv
/*
  Self-checking bench for the sequencer configuration and status block.
  Assumes the computation model sits on the far side and a 100 MHz system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module adcsq_config_status_tb;
  import adcsq_pkg::*;
  logic        CLOCK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic        start = 1'b0;
  logic        dbl = 1'b0;
  logic        divided = 1'b0;
  logic        ovf = 1'b0;
  logic [15:0] err = 16'h0;
  logic [15:0] uth = 16'h0;
  logic [15:0] lth = 16'h0;
  logic        comp_done, comp_ovf, conv_done, nref, thr_chk, conv_clk;
  logic [15:0] err_val;
  logic [7:0]  trig;
  logic [2:0]  stage;
  logic [1:0]  pref;
  logic [5:0]  chan;
  logic [4:0]  cap;
  logic [31:0] q;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          runs = 0;
  int          exp_thr = 0;
  int          thr_count = 0;
  int          clk_edges = 0;
  logic        prev_clk;
  int          cnt [8];
  logic [4:0]  r_addr [9] = '{ADDR_CLKDIV, ADDR_REF, ADDR_CHAN, ADDR_PRE, ADDR_ACQ,
                             ADDR_CAP, ADDR_RPT, ADDR_STATUS, 5'h02};
  logic [7:0]  r_exp [9] = '{8'h3f, 8'h13, 8'h3f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h00, 8'h00};
  logic [15:0] c_err [4] = '{16'h0005, 16'h0004, 16'hfffe, 16'h0000};
  logic [15:0] c_uth [4] = '{16'h0004, 16'h0004, 16'h000a, 16'h0000};
  logic [15:0] c_lth [4] = '{16'h0000, 16'h0004, 16'hffff, 16'h0000};
  logic        c_ovf [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [7:0]  c_exp [4] = '{8'h50, 8'h90, 8'h30, 8'h10};

  adcsq_config_status i_adcsq_config_status (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .START(start), .DOUBLE_SAMPLE(dbl),
    .USE_DIVIDED_CLOCK(divided), .COMP_DONE(comp_done), .COMP_OVERFLOW(comp_ovf),
    .ERROR_VALUE(err_val), .UPPER_THRESHOLD(uth), .LOWER_THRESHOLD(lth),
    .TRIGGER_COUNTER(trig), .SEQUENCER_STAGE(stage), .CONV_CLK(conv_clk),
    .CONV_DONE(conv_done), .NEGATIVE_REF_SELECT(nref), .POSITIVE_REF_SELECT(pref),
    .POSITIVE_CHANNEL_FIELD(chan), .EXTRA_CAP_FIELD(cap), .THRESHOLD_CHECK(thr_chk)
  );

  adcsq_comp_model i_adcsq_comp_model (
    .clk(CLOCK), .reset_n(RESET_N), .conv_done(conv_done), .ovf_in(ovf), .err_in(err),
    .comp_done(comp_done), .comp_overflow(comp_ovf), .error_value(err_val),
    .trigger_counter(trig)
  );

  initial begin
    forever #5 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    cycles++;
    if (thr_chk === 1'b1) begin
      thr_count++;
    end
    if (cycles == 20000) begin
      bad_count++;
      $display("FAIL timeout expected finish seen hang");
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge CLOCK); while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    repeat (10) @(posedge CLOCK);
    RESET_N <= 1'b1;
  endtask

  // Runs one conversion cycle and counts the cycles spent under each stage code.
  task automatic run(input logic [7:0] p, input logic [7:0] a, input logic [7:0] dv,
                     input logic dd, input logic uc, input int e [8]);
    bus(1'b1, ADDR_PRE, p);
    bus(1'b1, ADDR_ACQ, a);
    bus(1'b1, ADDR_CLKDIV, dv);
    foreach (cnt[k]) cnt[k] = 0;
    @(posedge CLOCK);
    dbl <= dd;
    divided <= uc;
    start <= 1'b1;
    @(posedge CLOCK);
    start <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      #1;
      if (conv_done === 1'b1) break;
      cnt[stage]++;
      @(posedge CLOCK);
    end
    foreach (e[k]) if (e[k] >= 0) check("stage cycles", cnt[k], e[k]);
    repeat (8) @(posedge CLOCK);
    runs++;
    if (runs >= 3) begin
      exp_thr++;
    end
  endtask

  initial begin
    do_reset();
    foreach (r_addr[i]) begin
      bus(1'b0, r_addr[i], 8'h00);
      check("reset value", q, 32'h0);
      bus(1'b1, r_addr[i], 8'hff);
      bus(1'b0, r_addr[i], 8'h00);
      check("readback", q, {24'h0, r_exp[i]});
    end
    check("config outputs", {nref, pref, chan, cap}, {1'b1, 2'h3, 6'h3f, 5'h1f});
    $display("test register rows done");
    for (logic [2:0] k = 3'h0; k < 3'h4; k++) begin
      bus(1'b1, ADDR_REF, {3'h0, k[0], 2'h0, k[1:0]});
      repeat (2) @(posedge CLOCK);
      check("reference selects", {nref, pref}, {k[0], k[1:0]});
    end
    $display("test reference codes done");
    do_reset();
    foreach (r_addr[i]) begin
      bus(1'b0, r_addr[i], 8'h00);
      check("value after reset", q, 32'h0);
    end
    check("outputs after reset", {nref, pref, chan, cap, stage}, 17'h0);
    $display("test second reset done");
    bus(1'b1, ADDR_RPT, 8'h03);
    run(8'h01, 8'h01, 8'hff, 1'b0, 1'b0, '{0, 1, 1, 11, 0, 0, 0, 0});
    run(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, '{0, 0, 0, 11, 0, 0, 0, 0});
    run(8'h02, 8'h00, 8'h00, 1'b0, 1'b0, '{0, 2, 256, 11, 0, 0, 0, 0});
    run(8'h01, 8'h01, 8'h00, 1'b1, 1'b0, '{0, 1, 1, 11, 0, 1, 1, 11});
    run(8'h01, 8'h03, 8'h01, 1'b0, 1'b1, '{-1, -1, 12, 44, 0, 0, 0, 0});
    run(8'h01, 8'h01, 8'hff, 1'b0, 1'b1, '{-1, -1, 128, 1408, 0, 0, 0, 0});
    $display("test stage timing done");
    foreach (c_err[i]) begin
      err <= c_err[i];
      uth <= c_uth[i];
      lth <= c_lth[i];
      ovf <= c_ovf[i];
      run(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, '{-1, -1, -1, -1, -1, -1, -1, -1});
      bus(1'b0, ADDR_STATUS, 8'h00);
      check("status flags", q, {24'h0, c_exp[i]});
      bus(1'b1, ADDR_STATUS, 8'h00);
      bus(1'b0, ADDR_STATUS, 8'h00);
      check("status cleared", q, {24'h0, c_exp[i] & 8'hef});
    end
    $display("test computation rows done");
    @(posedge CLOCK);
    start <= 1'b1;
    @(posedge CLOCK);
    start <= 1'b0;
    do @(posedge CLOCK); while (conv_done !== 1'b1);
    @(posedge CLOCK);
    bus(1'b1, ADDR_STATUS, 8'h00);
    bus(1'b0, ADDR_STATUS, 8'h00);
    check("update beats clear", q, 32'h10);
    exp_thr++;
    $display("test update race done");
    bus(1'b1, ADDR_CLKDIV, 8'h01);
    divided <= 1'b1;
    repeat (4) @(posedge CLOCK);
    for (int i = 0; i < 8; i++) begin
      prev_clk = conv_clk;
      @(posedge CLOCK);
      if (prev_clk === 1'b0 && conv_clk === 1'b1) clk_edges++;
    end
    check("converter clock edges", clk_edges, 2);
    check("threshold checks", thr_count, exp_thr);
    $display("test converter clock done");
    end_of_test();
  end
endmodule
`default_nettype wire

// File: logic/adcsq_clk_div.sv
/*
  Converter clock divider: divides the system clock by twice the field plus two.
  Assumes the divider field comes straight from a software register.
*/
`timescale 1ns/10ps
`default_nettype none
module adcsq_clk_div (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [5:0] div_field,
  output var  logic       tick,
  output var  logic       conv_clk
);
  logic [6:0] count_reg;
  logic [6:0] limit;

  assign limit = {div_field, 1'b1};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 7'h00;
      tick      <= 1'b0;
      conv_clk  <= 1'b0;
    end else begin
      if (count_reg >= limit) begin
        count_reg <= 7'h00;
        tick      <= 1'b1;
      end else begin
        count_reg <= count_reg + 7'h01;
        tick      <= 1'b0;
      end
      conv_clk <= (count_reg <= {1'b0, div_field});
    end
  end

  div_period_a: assert property (@(posedge clk) disable iff (!reset_n)
    tick |-> $past(count_reg) >= $past(limit)) else $error("Divider tick out of period.");
endmodule
`default_nettype wire

// File: logic/adcsq_config_status.sv
/*
  Configuration and status registers of a 10-bit converter sequencer, with its stage machine.
  Assumes an Avalon-MM master on the system clock and a computation unit that pulses on done.
*/
`timescale 1ns/10ps
`default_nettype none
module adcsq_config_status
  import adcsq_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output var  logic [31:0] AVS_READDATA,
  output var  logic        AVS_WAITREQUEST,
  input  wire logic        START,
  input  wire logic        DOUBLE_SAMPLE,
  input  wire logic        USE_DIVIDED_CLOCK,
  input  wire logic        COMP_DONE,
  input  wire logic        COMP_OVERFLOW,
  input  wire logic [15:0] ERROR_VALUE,
  input  wire logic [15:0] UPPER_THRESHOLD,
  input  wire logic [15:0] LOWER_THRESHOLD,
  input  wire logic [7:0]  TRIGGER_COUNTER,
  output var  logic [2:0]  SEQUENCER_STAGE,
  output var  logic        CONV_CLK,
  output var  logic        CONV_DONE,
  output var  logic        NEGATIVE_REF_SELECT,
  output var  logic [1:0]  POSITIVE_REF_SELECT,
  output var  logic [5:0]  POSITIVE_CHANNEL_FIELD,
  output var  logic [4:0]  EXTRA_CAP_FIELD,
  output var  logic        THRESHOLD_CHECK
);
  import adcsq_pkg::*;

  logic [7:0]      status_reg;
  logic [7:0]      clkdiv_reg;
  logic [7:0]      ref_reg;
  logic [7:0]      chan_reg;
  logic [7:0]      pre_reg;
  logic [7:0]      acq_reg;
  logic [7:0]      cap_reg;
  logic [7:0]      rpt_reg;
  logic            wait_reg;
  logic            take_write;
  logic            take_read;
  logic [7:0]      wbyte;
  logic [7:0]      rd_next;
  logic            clear_upd;
  adcsq_state_type state_reg;
  adcsq_state_type state_next;
  logic [8:0]      count_reg;
  logic [8:0]      count_next;
  logic            adc_tick;
  logic            div_tick;
  logic            div_clk;

  function automatic logic [8:0] stage_len(adcsq_state_type st, logic [7:0] pre,
                                           logic [7:0] acq);
    logic [8:0] len;
    len = CONV_CLOCKS;
    case (st)
      ST_PRE1, ST_PRE2: begin
        len = {1'b0, pre};
      end
      ST_ACQ1, ST_ACQ2: begin
        len = (acq == 8'h00) ? ACQ_ZERO_LEN : {1'b0, acq};
      end
      default: begin
        len = CONV_CLOCKS;
      end
    endcase
    return len;
  endfunction

  function automatic adcsq_state_type entry_state(logic second, logic [7:0] pre,
                                                  logic [7:0] acq);
    adcsq_state_type st;
    if (pre != 8'h00) begin
      st = second ? ST_PRE2 : ST_PRE1;
    end else if (acq != 8'h00) begin
      st = second ? ST_ACQ2 : ST_ACQ1;
    end else begin
      st = second ? ST_CONV2 : ST_CONV1;
    end
    return st;
  endfunction

  function automatic logic [2:0] stage_code(adcsq_state_type st);
    logic [2:0] code;
    case (st)
      ST_PRE1:  code = CODE_PRE1;
      ST_ACQ1:  code = CODE_ACQ1;
      ST_CONV1: code = CODE_CONV1;
      ST_PRE2:  code = CODE_PRE2;
      ST_ACQ2:  code = CODE_ACQ2;
      ST_CONV2: code = CODE_CONV2;
      default:  code = CODE_IDLE;
    endcase
    return code;
  endfunction

  // Bus slave: one wait cycle; reads are taken during it, writes after it.
  assign take_write = AVS_WRITE && !wait_reg;
  assign take_read  = AVS_READ && wait_reg;
  assign wbyte      = AVS_WRITEDATA[7:0];
  assign clear_upd  = take_write && (AVS_ADDRESS == ADDR_STATUS) && AVS_BYTEENABLE[0]
                      && !wbyte[UPD_BIT];

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wait_reg <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  always_comb begin
    case (AVS_ADDRESS)
      ADDR_STATUS: rd_next = {status_reg[7:4], 1'b0, stage_code(state_reg)};
      ADDR_CLKDIV: rd_next = clkdiv_reg;
      ADDR_REF:    rd_next = ref_reg;
      ADDR_CHAN:   rd_next = chan_reg;
      ADDR_PRE:    rd_next = pre_reg;
      ADDR_ACQ:    rd_next = acq_reg;
      ADDR_CAP:    rd_next = cap_reg;
      ADDR_RPT:    rd_next = rpt_reg;
      default:     rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (take_read) begin
      AVS_READDATA <= {24'h00_0000, rd_next};
    end
  end

  // Writable configuration; masks keep unimplemented bits at zero.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      clkdiv_reg <= REG_RESET;
      ref_reg    <= REG_RESET;
      chan_reg   <= REG_RESET;
      pre_reg    <= REG_RESET;
      acq_reg    <= REG_RESET;
      cap_reg    <= REG_RESET;
      rpt_reg    <= REG_RESET;
    end else if (take_write && AVS_BYTEENABLE[0]) begin
      case (AVS_ADDRESS)
        ADDR_CLKDIV: begin
          clkdiv_reg <= wbyte & CLKDIV_MASK;
        end
        ADDR_REF: begin
          ref_reg <= wbyte & REF_MASK;
        end
        ADDR_CHAN: begin
          chan_reg <= wbyte & CHAN_MASK;
        end
        ADDR_PRE: begin
          pre_reg <= wbyte;
        end
        ADDR_ACQ: begin
          acq_reg <= wbyte;
        end
        ADDR_CAP: begin
          cap_reg <= wbyte & CAP_MASK;
        end
        ADDR_RPT: begin
          rpt_reg <= wbyte;
        end
        default: begin
          rpt_reg <= rpt_reg;
        end
      endcase
    end
  end

  // Status flags follow the computation unit; only the update bit is writable.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_reg <= REG_RESET;
    end else begin
      if (COMP_DONE) begin
        status_reg[OVF_BIT] <= COMP_OVERFLOW;
        status_reg[UTH_BIT] <= $signed(ERROR_VALUE) > $signed(UPPER_THRESHOLD);
        status_reg[LTH_BIT] <= $signed(ERROR_VALUE) < $signed(LOWER_THRESHOLD);
        status_reg[UPD_BIT] <= 1'b1;
      end else if (clear_upd) begin
        status_reg[UPD_BIT] <= 1'b0;
      end
      status_reg[3:0] <= 4'h0;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      THRESHOLD_CHECK <= 1'b0;
    end else begin
      THRESHOLD_CHECK <= COMP_DONE && (TRIGGER_COUNTER >= rpt_reg);
    end
  end

  adcsq_clk_div u_div (
    .clk       (CLOCK),
    .reset_n   (RESET_N),
    .div_field (clkdiv_reg[5:0]),
    .tick      (div_tick),
    .conv_clk  (div_clk)
  );

  // System clock source counts every edge and ignores the divider.
  assign adc_tick = USE_DIVIDED_CLOCK ? div_tick : 1'b1;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    if (state_reg == ST_IDLE) begin
      if (START) begin
        state_next = entry_state(1'b0, pre_reg, acq_reg);
        count_next = stage_len(state_next, pre_reg, acq_reg) - 9'h001;
      end
    end else if (adc_tick) begin
      if (count_reg != 9'h000) begin
        count_next = count_reg - 9'h001;
      end else begin
        case (state_reg)
          ST_PRE1: begin
            state_next = ST_ACQ1;
          end
          ST_ACQ1: begin
            state_next = ST_CONV1;
          end
          ST_CONV1: begin
            state_next = DOUBLE_SAMPLE ? entry_state(1'b1, pre_reg, acq_reg) : ST_IDLE;
          end
          ST_PRE2: begin
            state_next = ST_ACQ2;
          end
          ST_ACQ2: begin
            state_next = ST_CONV2;
          end
          default: begin
            state_next = ST_IDLE;
          end
        endcase
        count_next = stage_len(state_next, pre_reg, acq_reg) - 9'h001;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      count_reg <= 9'h000;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Stage output is exact here since the whole sequencer runs on the system clock.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      SEQUENCER_STAGE <= CODE_IDLE;
      CONV_DONE       <= 1'b0;
      CONV_CLK        <= 1'b0;
    end else begin
      SEQUENCER_STAGE <= stage_code(state_next);
      CONV_DONE       <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
      CONV_CLK        <= USE_DIVIDED_CLOCK ? div_clk : 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      NEGATIVE_REF_SELECT    <= 1'b0;
      POSITIVE_REF_SELECT    <= 2'h0;
      POSITIVE_CHANNEL_FIELD <= 6'h00;
      EXTRA_CAP_FIELD        <= 5'h00;
      AVS_WAITREQUEST        <= 1'b1;
    end else begin
      NEGATIVE_REF_SELECT    <= ref_reg[NREF_BIT];
      POSITIVE_REF_SELECT    <= ref_reg[1:0];
      POSITIVE_CHANNEL_FIELD <= chan_reg[5:0];
      EXTRA_CAP_FIELD        <= cap_reg[4:0];
      AVS_WAITREQUEST        <= !((AVS_READ || AVS_WRITE) && wait_reg);
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  sequence start_short_s;
    state_reg == ST_IDLE && START && !USE_DIVIDED_CLOCK && pre_reg == 8'h01
      && acq_reg == 8'h01;
  endsequence
  sequence pre_then_acq_s;
    state_reg == ST_PRE1 ##1 state_reg == ST_ACQ1 ##1 state_reg == ST_CONV1;
  endsequence

  overflow_capture_a: assert property (
    COMP_DONE |=> status_reg[OVF_BIT] == $past(COMP_OVERFLOW))
    else $error("Overflow flag not captured.");
  upper_flag_a: assert property (COMP_DONE |=> status_reg[UTH_BIT] ==
    ($signed($past(ERROR_VALUE)) > $signed($past(UPPER_THRESHOLD))))
    else $error("Upper flag wrong.");
  lower_flag_a: assert property (COMP_DONE |=> status_reg[LTH_BIT] ==
    ($signed($past(ERROR_VALUE)) < $signed($past(LOWER_THRESHOLD))))
    else $error("Lower flag wrong.");
  update_hold_a: assert property (
    !COMP_DONE && !clear_upd |=> $stable(status_reg[UPD_BIT]))
    else $error("Update flag changed without cause.");
  update_set_a: assert property (COMP_DONE && clear_upd |=> status_reg[UPD_BIT])
    else $error("Clear beat a simultaneous update.");
  stage_code_a: assert property (SEQUENCER_STAGE != CODE_UNUSED)
    else $error("Unused stage code shown.");
  status_ro_a: assert property (!COMP_DONE |=> $stable(status_reg[7:5]))
    else $error("Read-only status bits changed.");
  skip_both_a: assert property (state_reg == ST_IDLE && START && pre_reg == 8'h00
    && acq_reg == 8'h00 |=> state_reg == ST_CONV1)
    else $error("Zero durations not skipped.");
  acq_256_a: assert property (state_next == ST_ACQ1 && state_reg != ST_ACQ1
    && acq_reg == 8'h00 |=> count_reg == 9'h0ff)
    else $error("Acquisition of 256 clocks not loaded.");
  undivided_a: assert property (start_short_s |=> pre_then_acq_s)
    else $error("Undivided durations wrong.");
  reserved_zero_a: assert property (
    !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h00_0000)
    else $error("Upper read bits not zero.");
endmodule
`default_nettype wire

// File: logic/adcsq_pkg.sv
/*
  Constants shared by the converter sequencer configuration and status block.
  Assumes a byte-addressed Avalon-MM bus with 32-bit data and one register per word.
*/
`default_nettype none
package adcsq_pkg;
  localparam logic [4:0] ADDR_STATUS  = 5'h00;
  localparam logic [4:0] ADDR_CLKDIV  = 5'h04;
  localparam logic [4:0] ADDR_REF     = 5'h08;
  localparam logic [4:0] ADDR_CHAN    = 5'h0c;
  localparam logic [4:0] ADDR_PRE     = 5'h10;
  localparam logic [4:0] ADDR_ACQ     = 5'h14;
  localparam logic [4:0] ADDR_CAP     = 5'h18;
  localparam logic [4:0] ADDR_RPT     = 5'h1c;
  localparam int         OVF_BIT      = 7;
  localparam int         UTH_BIT      = 6;
  localparam int         LTH_BIT      = 5;
  localparam int         UPD_BIT      = 4;
  localparam int         NREF_BIT     = 4;
  localparam logic [7:0] CLKDIV_MASK  = 8'h3f;
  localparam logic [7:0] REF_MASK     = 8'h13;
  localparam logic [7:0] CHAN_MASK    = 8'h3f;
  localparam logic [7:0] CAP_MASK     = 8'h1f;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [8:0] CONV_CLOCKS  = 9'h00b;
  localparam logic [8:0] ACQ_ZERO_LEN = 9'h100;
  localparam logic [2:0] CODE_IDLE    = 3'h0;
  localparam logic [2:0] CODE_PRE1    = 3'h1;
  localparam logic [2:0] CODE_ACQ1    = 3'h2;
  localparam logic [2:0] CODE_CONV1   = 3'h3;
  localparam logic [2:0] CODE_UNUSED  = 3'h4;
  localparam logic [2:0] CODE_PRE2    = 3'h5;
  localparam logic [2:0] CODE_ACQ2    = 3'h6;
  localparam logic [2:0] CODE_CONV2   = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE1, ST_ACQ1, ST_CONV1, ST_PRE2, ST_ACQ2, ST_CONV2
  } adcsq_state_type;
endpackage
`default_nettype wire
